/* cai_aux_func.sv */
// Auxiliary input functions of a dual counter with an APB register slave.
`timescale 1ns/10ps
module cai_aux_func #(
  parameter int CNT_W = cai_pkg::CNT_W
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cai_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] auxPin,
  input wire logic [1:0] countTick,
  output logic [1:0] counterEnable,
  output logic [1:0] pwmAuxRoute,
  output logic [1:0] pwmAuxLevel
);

  cai_aux_if #(.N(2)) auxBus ();

  cai_aux_sync #(.N(2)) u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .auxPin(auxPin),
    .aux(auxBus)
  );

  logic [7:0] ctrl_r [2];
  logic [7:0] ctrl_nxt [2];
  logic [7:0] mode_r, mode_nxt;
  logic [CNT_W-1:0] load_r [2];
  logic [CNT_W-1:0] load_nxt [2];
  logic [CNT_W-1:0] count_r [2];
  logic [CNT_W-1:0] count_nxt [2];
  logic [CNT_W-1:0] latch_r [2];
  logic [CNT_W-1:0] latch_nxt [2];
  logic [1:0] sfEv_r, sfEv_nxt, swEv_r, swEv_nxt, armed_r, armed_nxt;
  logic [1:0] gateOpen_r, gateOpen_nxt, softPrev_r, softPrev_nxt;
  logic [1:0] clrPrev_r, clrPrev_nxt, enOut_r, enOut_nxt;
  logic [1:0] route_r, route_nxt, pwmLvl_r, pwmLvl_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic dataOk_r, dataOk_nxt;

  cai_pkg::cai_func_type code [2];
  logic [1:0] paired, pairOn, gateMode, gateLvl, hwGateOpen, cntEn, syncMode;
  logic [1:0] oneShotEff, hwRetrig, swRetrig, alarmSet, gateRise, sfSet, clrPulse;
  logic [1:0] codeRsvd, pwmCode, sfOff, globalOff;
  logic [31:0] stsWord;
  logic wrEn;

  function automatic logic isMapped(input logic [cai_pkg::APB_AW-1:0] a);
    return (a == cai_pkg::OFS_CTRL0) || (a == cai_pkg::OFS_CTRL1) ||
           (a == cai_pkg::OFS_MODE) || (a == cai_pkg::OFS_STATUS) ||
           (a == cai_pkg::OFS_LOAD0) || (a == cai_pkg::OFS_LOAD1) ||
           (a == cai_pkg::OFS_COUNT0) || (a == cai_pkg::OFS_COUNT1) ||
           (a == cai_pkg::OFS_LATCH0) || (a == cai_pkg::OFS_LATCH1);
  endfunction

  function automatic logic isCode(input cai_pkg::cai_func_type k, input cai_pkg::cai_func_type v);
    return k == v;
  endfunction

  // Channel function decode, event flags and counter datapath.
  always_comb begin
    stsWord = cai_pkg::WORD_RST;
    mode_nxt = mode_r;
    if (wrEn && (paddr == cai_pkg::OFS_MODE)) begin
      mode_nxt = pwdata[7:0];
    end
    for (int c = 0; c < 2; c++) begin
      code[c] = cai_pkg::cai_func_type'(mode_r[4*c +: 4]);
      sfOff[c] = ctrl_r[c][cai_pkg::CTL_SF_OFF];
      globalOff[c] = ctrl_r[c][cai_pkg::CTL_GLOBAL_OFF];
      paired[c] = isCode(code[c], cai_pkg::FN_PAIR_ONE) ||
                  isCode(code[c], cai_pkg::FN_PAIR_RUN);
      // One combined enable switches both inputs of the pair at once.
      pairOn[c] = paired[c] && ctrl_r[c][cai_pkg::CTL_COMBINED_EN]; // RULE_10
      gateMode[c] = isCode(code[c], cai_pkg::FN_GATE) || pairOn[c]; // RULE_02
      // In a pair the gate comes from the partner input.
      gateLvl[c] = paired[c] ? auxBus.lvl[1-c] : auxBus.lvl[c]; // RULE_08 RULE_09
      hwGateOpen[c] = gateMode[c] && !sfOff[c] && gateLvl[c]; // RULE_02
      cntEn[c] = ctrl_r[c][cai_pkg::CTL_SW_GATE] || hwGateOpen[c]; // RULE_03
      syncMode[c] = isCode(code[c], cai_pkg::FN_SYNC_ONE) || // RULE_06
                    isCode(code[c], cai_pkg::FN_SYNC_RUN) || pairOn[c]; // RULE_07
      // Counter 2 in the paired continuous code follows the one-shot bit.
      oneShotEff[c] = ctrl_r[c][cai_pkg::CTL_ONE_SHOT] || // RULE_15
                      isCode(code[c], cai_pkg::FN_SYNC_ONE) ||
                      isCode(code[c], cai_pkg::FN_PAIR_ONE) ||
                      (isCode(code[c], cai_pkg::FN_PAIR_RUN) && (c == 0));
      hwRetrig[c] = syncMode[c] && auxBus.rise[c] && !globalOff[c] && // RULE_16
                    !sfOff[c] && armed_r[c]; // RULE_19
      swRetrig[c] = ctrl_r[c][cai_pkg::CTL_SOFT_CAPTURE] && !softPrev_r[c] &&
                    !globalOff[c]; // RULE_17
      alarmSet[c] = isCode(code[c], cai_pkg::FN_ALARM) && auxBus.rise[c] &&
                    !sfOff[c]; // RULE_01
      gateRise[c] = hwGateOpen[c] && !gateOpen_r[c]; // RULE_04
      sfSet[c] = alarmSet[c] || gateRise[c] || hwRetrig[c];
      // Clear fires on the 1 to 0 step, closing the 0, 1, 0 sequence.
      clrPulse[c] = clrPrev_r[c] && !ctrl_r[c][cai_pkg::CTL_MSG_CLEAR]; // RULE_14
      // A set in the clearing cycle wins so no event is lost.
      sfEv_nxt[c] = sfSet[c] || (sfEv_r[c] && !clrPulse[c]); // RULE_14
      swEv_nxt[c] = swRetrig[c] || (swEv_r[c] && !clrPulse[c]); // RULE_17
      armed_nxt[c] = armed_r[c];
      if (sfOff[c]) begin
        armed_nxt[c] = 1'b1;
      end else if (hwRetrig[c] && oneShotEff[c]) begin
        armed_nxt[c] = 1'b0; // RULE_15
      end
      codeRsvd[c] = isCode(code[c], cai_pkg::FN_RSVD_LO) ||
                    ((code[c] > cai_pkg::FN_PWM_LAST) && (code[c] < cai_pkg::FN_DIGIN)); // RULE_11
      pwmCode[c] = (code[c] >= cai_pkg::FN_PWM_FIRST) && (code[c] <= cai_pkg::FN_PWM_LAST);
      route_nxt[c] = pwmCode[c]; // RULE_11
      pwmLvl_nxt[c] = pwmCode[c] && auxBus.lvl[c]; // RULE_11
      enOut_nxt[c] = cntEn[c] && !globalOff[c];
      gateOpen_nxt[c] = hwGateOpen[c];
      softPrev_nxt[c] = ctrl_r[c][cai_pkg::CTL_SOFT_CAPTURE];
      clrPrev_nxt[c] = ctrl_r[c][cai_pkg::CTL_MSG_CLEAR];

      ctrl_nxt[c] = ctrl_r[c];
      load_nxt[c] = load_r[c];
      if (wrEn && (paddr == ((c == 0) ? cai_pkg::OFS_CTRL0 : cai_pkg::OFS_CTRL1))) begin
        ctrl_nxt[c] = pwdata[7:0];
      end
      if (wrEn && (paddr == ((c == 0) ? cai_pkg::OFS_LOAD0 : cai_pkg::OFS_LOAD1))) begin
        load_nxt[c] = pwdata[CNT_W-1:0];
      end
      // Capture first, then reload; the reload beats a tick or a bus write.
      latch_nxt[c] = latch_r[c];
      count_nxt[c] = count_r[c];
      if (hwRetrig[c] || swRetrig[c]) begin
        latch_nxt[c] = count_r[c]; // RULE_13
        count_nxt[c] = load_r[c]; // RULE_13
      end else if (wrEn && (paddr == ((c == 0) ? cai_pkg::OFS_COUNT0
                                                : cai_pkg::OFS_COUNT1))) begin
        count_nxt[c] = pwdata[CNT_W-1:0];
      end else if (enOut_nxt[c] && countTick[c]) begin
        // The gate only steers the increment, the count itself is kept.
        count_nxt[c] = count_r[c] + CNT_W'(1); // RULE_05
      end

      stsWord[c*cai_pkg::STS_PER_CH + cai_pkg::STS_SF_EVENT] = sfEv_r[c];
      stsWord[c*cai_pkg::STS_PER_CH + cai_pkg::STS_SOFT_EVENT] = swEv_r[c];
      stsWord[c*cai_pkg::STS_PER_CH + cai_pkg::STS_SF_ON_ACK] = !sfOff[c]; // RULE_18
      stsWord[c*cai_pkg::STS_PER_CH + cai_pkg::STS_CNT_EN] = enOut_r[c];
      // The filtered level is always visible, which serves the digital input code.
      stsWord[c*cai_pkg::STS_PER_CH + cai_pkg::STS_AUX_LEVEL] = auxBus.lvl[c]; // RULE_12
      stsWord[c*cai_pkg::STS_PER_CH + cai_pkg::STS_PWM_ROUTE] = route_r[c];
      stsWord[c*cai_pkg::STS_PER_CH + cai_pkg::STS_CODE_RSVD] = codeRsvd[c];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int c = 0; c < 2; c++) begin
        ctrl_r[c] <= cai_pkg::CTRL_RST; // RULE_18
        load_r[c] <= CNT_W'(cai_pkg::WORD_RST);
        count_r[c] <= CNT_W'(cai_pkg::WORD_RST);
        latch_r[c] <= CNT_W'(cai_pkg::WORD_RST);
      end
      mode_r <= cai_pkg::MODE_RST;
      sfEv_r <= '0;
      swEv_r <= '0;
      armed_r <= '1;
      gateOpen_r <= '0;
      softPrev_r <= '0;
      clrPrev_r <= '0;
      enOut_r <= '0;
      route_r <= '0;
      pwmLvl_r <= '0;
    end else if (clkEn) begin
      for (int c = 0; c < 2; c++) begin
        ctrl_r[c] <= ctrl_nxt[c];
        load_r[c] <= load_nxt[c];
        count_r[c] <= count_nxt[c];
        latch_r[c] <= latch_nxt[c];
      end
      mode_r <= mode_nxt;
      sfEv_r <= sfEv_nxt;
      swEv_r <= swEv_nxt;
      armed_r <= armed_nxt;
      gateOpen_r <= gateOpen_nxt;
      softPrev_r <= softPrev_nxt;
      clrPrev_r <= clrPrev_nxt;
      enOut_r <= enOut_nxt;
      route_r <= route_nxt;
      pwmLvl_r <= pwmLvl_nxt;
    end
  end

  // Read data are snapshotted before the access completes, so the answer
  // always comes from a flip-flop; the price is one setup cycle of latency.
  always_comb begin
    pready = psel && penable && clkEn && dataOk_r;
    pslverr = pready && !isMapped(paddr);
    wrEn = pready && pwrite && isMapped(paddr);
    dataOk_nxt = psel && !pready;
    prdata_nxt = prdata_r;
    if (psel && !dataOk_r) begin
      unique case (paddr)
        cai_pkg::OFS_CTRL0: prdata_nxt = {24'h00_0000, ctrl_r[0]};
        cai_pkg::OFS_CTRL1: prdata_nxt = {24'h00_0000, ctrl_r[1]};
        cai_pkg::OFS_MODE: prdata_nxt = {24'h00_0000, mode_r};
        cai_pkg::OFS_STATUS: prdata_nxt = stsWord;
        cai_pkg::OFS_LOAD0: prdata_nxt = 32'(load_r[0]);
        cai_pkg::OFS_LOAD1: prdata_nxt = 32'(load_r[1]);
        cai_pkg::OFS_COUNT0: prdata_nxt = 32'(count_r[0]);
        cai_pkg::OFS_COUNT1: prdata_nxt = 32'(count_r[1]);
        cai_pkg::OFS_LATCH0: prdata_nxt = 32'(latch_r[0]);
        cai_pkg::OFS_LATCH1: prdata_nxt = 32'(latch_r[1]);
        default: prdata_nxt = cai_pkg::WORD_RST;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prdata_r <= cai_pkg::WORD_RST;
      dataOk_r <= 1'b0;
    end else if (clkEn) begin
      prdata_r <= prdata_nxt;
      dataOk_r <= dataOk_nxt;
    end
  end

  assign prdata = prdata_r;
  assign counterEnable = enOut_r;
  assign pwmAuxRoute = route_r;
  assign pwmAuxLevel = pwmLvl_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  chk_alarm_sets_flag: assert property ( // RULE_01
    clkEn && (mode_r[3:0] == 4'h0) && auxBus.rise[0] && !ctrl_r[0][cai_pkg::CTL_SF_OFF]
    |=> sfEv_r[0]) else $error("alarm edge did not set the event flag");
  chk_gate_follows_pin: assert property ( // RULE_02
    (mode_r[3:0] == 4'h1) && !ctrl_r[0][cai_pkg::CTL_SF_OFF] &&
    !ctrl_r[0][cai_pkg::CTL_SW_GATE] && !ctrl_r[0][cai_pkg::CTL_GLOBAL_OFF] && clkEn
    |=> counterEnable[0] == $past(auxBus.lvl[0])) else $error("gate does not follow input");
  chk_soft_gate_path: assert property ( // RULE_03
    clkEn && ctrl_r[0][cai_pkg::CTL_SW_GATE] && !ctrl_r[0][cai_pkg::CTL_GLOBAL_OFF]
    |=> counterEnable[0]) else $error("software gate did not enable counter");
  chk_gate_open_flag: assert property ( // RULE_04
    clkEn && $rose(hwGateOpen[0]) |=> sfEv_r[0]) else $error("gate opening not flagged");
  chk_count_kept: assert property ( // RULE_05
    clkEn && !countTick[0] && !hwRetrig[0] && !swRetrig[0] && !wrEn
    |=> count_r[0] == $past(count_r[0])) else $error("count changed without cause");
  chk_retrig_order: assert property ( // RULE_13
    clkEn && hwRetrig[0] |=> (latch_r[0] == $past(count_r[0])) &&
    (count_r[0] == $past(load_r[0]))) else $error("retrigger did not capture and reload");
  chk_one_shot_once: assert property ( // RULE_15
    clkEn && hwRetrig[0] && oneShotEff[0] |=> !armed_r[0] ##1 !hwRetrig[0] || sfOff[0])
    else $error("one-shot retriggered twice");
  chk_retrig_qualify: assert property ( // RULE_16
    hwRetrig[1] |-> !globalOff[1] && !sfOff[1] && auxBus.rise[1])
    else $error("retrigger without its conditions");
  chk_soft_capture: assert property ( // RULE_17
    clkEn && swRetrig[1] |=> swEv_r[1] && (latch_r[1] == $past(count_r[1])))
    else $error("soft capture not carried out");
  chk_clear_sequence: assert property ( // RULE_14
    clkEn && clrPulse[0] && !sfSet[0] |=> !sfEv_r[0]) else $error("message clear ignored");
  chk_on_ack: assert property ( // RULE_18
    stsWord[cai_pkg::STS_SF_ON_ACK] == !ctrl_r[0][cai_pkg::CTL_SF_OFF])
    else $error("special function acknowledge wrong");

  // Second channel and the code groups; the reload, gate, route and capture checks watch the counter side, so a
  // decode slip shows up as a wrong latch, enable or route rather than a flag.
  chk_reload_second: assert property ( // RULE_06 RULE_07
    clkEn && hwRetrig[1] |=> (latch_r[1] == $past(count_r[1])) &&
    (count_r[1] == $past(load_r[1]))) else $error("second channel retrigger wrong");
  chk_pair_gate: assert property ( // RULE_08 RULE_09
    clkEn && pairOn[1] && !sfOff[1] && !globalOff[1] && !ctrl_r[1][cai_pkg::CTL_SW_GATE]
    |=> counterEnable[1] == $past(auxBus.lvl[0])) else $error("paired gate not from partner");
  chk_pair_enable: assert property ( // RULE_10
    paired[0] && !ctrl_r[0][cai_pkg::CTL_COMBINED_EN]
    |-> !hwGateOpen[0] && !hwRetrig[0]) else $error("paired inputs acted while off");
  chk_pwm_route: assert property ( // RULE_11
    clkEn && (mode_r[7:4] >= 4'h7) && (mode_r[7:4] <= 4'h9)
    |=> pwmAuxRoute[1]) else $error("input not handed to pulse output");
  chk_rsvd_inert: assert property ( // RULE_11
    codeRsvd[0] |-> !hwRetrig[0] && !alarmSet[0] && !hwGateOpen[0])
    else $error("reserved code touched the counter");
  chk_digin_inert: assert property ( // RULE_12
    (mode_r[7:4] == 4'hF) |-> !hwRetrig[1] && !alarmSet[1] && !hwGateOpen[1] && !pwmCode[1])
    else $error("digital input code touched the counter");
  chk_periodic_rearm: assert property ( // RULE_19
    clkEn && hwRetrig[1] && !oneShotEff[1] |=> armed_r[1])
    else $error("periodic synchronisation disarmed");
  chk_soft_blocked: assert property ( // RULE_17
    clkEn && globalOff[0] |=> latch_r[0] == $past(latch_r[0]))
    else $error("capture while counter globally off");
  chk_sf_off_inert: assert property ( // RULE_16
    clkEn && sfOff[0] && !swRetrig[0] |=> latch_r[0] == $past(latch_r[0]))
    else $error("hardware capture while special function off");

  cov_hw_retrig: cover property (clkEn && hwRetrig[0]);
  cov_soft_retrig: cover property (clkEn && swRetrig[1]);
  cov_gate_open: cover property (clkEn && gateRise[1] && pairOn[1]);
  cov_bus_error: cover property (pslverr);
  cov_pair_periodic: cover property (clkEn && hwRetrig[1] && pairOn[1]);

endmodule // cai_aux_func

/* cai_aux_if.sv */
// Carrier for the filtered auxiliary input levels and their rising edges.
`timescale 1ns/10ps
interface cai_aux_if #(parameter int N = 2);
  logic [N-1:0] lvl;
  logic [N-1:0] rise;
  modport src (output lvl, output rise);
  modport dst (input lvl, input rise);
endinterface // cai_aux_if

/* cai_aux_sync.sv */
// Three-stage input synchroniser and agreement filter for the auxiliary pins.
`timescale 1ns/10ps
module cai_aux_sync #(
  parameter int N = 2
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic [N-1:0] auxPin,
  cai_aux_if.src aux
);

  logic [N-1:0] s1_r, s2_r, s3_r, lvl_r, rise_r;
  logic [N-1:0] s1_nxt, s2_nxt, s3_nxt, lvl_nxt, rise_nxt;

  // A level only counts once stages two and three agree, so a glitch that
  // lives for a single sample never reaches the counter logic.
  always_comb begin
    s1_nxt = auxPin;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    lvl_nxt = lvl_r;
    for (int i = 0; i < N; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        lvl_nxt[i] = s3_r[i];
      end
    end
    rise_nxt = lvl_nxt & ~lvl_r;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      lvl_r <= '0;
      rise_r <= '0;
    end else if (clkEn) begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      lvl_r <= lvl_nxt;
      rise_r <= rise_nxt;
    end
  end

  assign aux.lvl = lvl_r;
  assign aux.rise = rise_r;

endmodule // cai_aux_sync

/* cai_field_model.sv */
// Field-side model that drives the two auxiliary input pins.
`timescale 1ns/10ps
module cai_field_model (
  input wire logic sys_clk,
  output logic [1:0] auxPin
);
  initial begin
    auxPin = 2'h0;
  end
  task automatic drive(input int ch, input logic v);
    @(posedge sys_clk);
    auxPin[ch] <= v;
  endtask
  // A switch or encoder pulse narrower than two clocks would be lost in the filter.
  task automatic pulse(input int ch, input int w);
    drive(ch, 1'h1);
    repeat ((w < 2) ? 2 : w) @(posedge sys_clk);
    auxPin[ch] <= 1'h0;
  endtask
endmodule // cai_field_model

/* cai_pkg.sv */
// Constants and types shared by the counter auxiliary input function block.
//
// Operation
// RULE_01 - Alarm code: each rising aux input edge sets the special-function event flag.
// RULE_02 - Hardware gate code: aux input low disables the counter, high enables it.
// RULE_03 - Counter may be enabled by the hardware gate or by the software gate.
// RULE_04 - Opening the hardware gate sets the special-function event flag.
// RULE_05 - Gate opening or closing changes only the enable, never the count.
// RULE_06 - Single capture-reload code: rising edge captures count, reloads, keeps counting.
// RULE_07 - Continuous capture-reload code: same capture and reload on rising edges.
// RULE_08 - Paired single code: own input synchronises, the other input gates.
// RULE_09 - Paired continuous code: same pairing, counter 2 synchronises periodically.
// RULE_10 - In paired codes one combined enable bit enables both inputs.
// RULE_11 - Codes 6 and 10 to 14 reserved; 7 to 9 route input to PWM.
// RULE_12 - Code 15 makes input a plain digital input reported in status.
// RULE_13 - Retrigger copies count to capture, reload to count, then counts on.
// RULE_14 - Retrigger sets event flag; message clear pulse 0, 1, 0 clears it.
// RULE_15 - One-shot bit set: only the first edge after enabling retriggers.
// RULE_16 - Hardware retrigger needs global off 0, special off 0, rising edge.
// RULE_17 - Soft capture bit rise captures, reloads, sets soft event unless global off.
// RULE_18 - Special function on by default, off when its bit is 1, acknowledged.
// RULE_19 - One-shot bit clear: every qualifying rising edge retriggers.
package cai_pkg;

  localparam int CNT_W = 32;
  localparam int APB_AW = 8;

  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_LOAD0 = 8'h10;
  localparam logic [7:0] OFS_LOAD1 = 8'h14;
  localparam logic [7:0] OFS_COUNT0 = 8'h18;
  localparam logic [7:0] OFS_COUNT1 = 8'h1C;
  localparam logic [7:0] OFS_LATCH0 = 8'h20;
  localparam logic [7:0] OFS_LATCH1 = 8'h24;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  localparam int CTL_SW_GATE = 0;
  localparam int CTL_SF_OFF = 1;
  localparam int CTL_GLOBAL_OFF = 2;
  localparam int CTL_MSG_CLEAR = 3;
  localparam int CTL_COMBINED_EN = 4;
  localparam int CTL_SOFT_CAPTURE = 5;
  localparam int CTL_ONE_SHOT = 6;

  localparam int STS_PER_CH = 8;
  localparam int STS_SF_EVENT = 0;
  localparam int STS_SOFT_EVENT = 1;
  localparam int STS_SF_ON_ACK = 2;
  localparam int STS_CNT_EN = 3;
  localparam int STS_AUX_LEVEL = 4;
  localparam int STS_PWM_ROUTE = 5;
  localparam int STS_CODE_RSVD = 6;

  typedef enum logic [3:0] {
    FN_ALARM = 4'h0,
    FN_GATE = 4'h1,
    FN_SYNC_ONE = 4'h2,
    FN_SYNC_RUN = 4'h3,
    FN_PAIR_ONE = 4'h4,
    FN_PAIR_RUN = 4'h5,
    FN_RSVD_LO = 4'h6,
    FN_PWM_FIRST = 4'h7,
    FN_PWM_LAST = 4'h9,
    FN_DIGIN = 4'hF
  } cai_func_type;

endpackage

/* counter_aux_input_functions_bench.sv */
// Self-checking bench for the counter auxiliary input functions.
`timescale 1ns/10ps
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin fails++; $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module counter_aux_input_functions_bench;
  logic sysClk, rstn, clkEn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat, v, v2, ld;
  logic [1:0] auxPin, countTick, counterEnable, pwmAuxRoute, pwmAuxLevel;
  logic rerr;
  logic [3:0] code;
  logic [31:0] ctl;
  int seed, fails, checksDone, cycles;
  int codes[7] = '{6, 7, 8, 9, 10, 14, 15};

  cai_aux_func i_cai_aux_func (.sys_clk(sysClk), .rstn(rstn), .clkEn(clkEn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .auxPin(auxPin), .countTick(countTick),
    .counterEnable(counterEnable), .pwmAuxRoute(pwmAuxRoute), .pwmAuxLevel(pwmAuxLevel));
  cai_field_model i_cai_field_model (.sys_clk(sysClk), .auxPin(auxPin));

  always #20 sysClk = ~sysClk;

  function automatic logic [31:0] exp_latch(int k, logic [31:0] first, logic [31:0] second);
    return (k == 1) ? second : first;
  endfunction
  function automatic logic exp_route(logic [3:0] c);
    return (c >= 4'h7) && (c <= 4'h9);
  endfunction
  function automatic logic exp_rsvd(logic [3:0] c);
    return (c == 4'h6) || ((c >= 4'hA) && (c <= 4'hE));
  endfunction

  // The request stands until pready is seen high at a rising edge; data are taken there.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge sysClk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge sysClk);
    penable <= 1'h1;
    do begin
      @(posedge sysClk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d, rdat, rerr);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0000_0000, rdat, rerr);
    `CHK(rdat, exp)
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sysClk);
  endtask
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge sysClk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end

  initial begin
    sysClk = 1'h0;
    rstn = 1'h0;
    clkEn = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    countTick = 2'h0;
    seed = 32'h0000_059b;
    repeat (5) @(posedge sysClk);
    rstn <= 1'h1;
    rdchk(cai_pkg::OFS_STATUS, 32'h0000_0404);
    rdchk(cai_pkg::OFS_MODE, 32'h0000_0000);
    apb(1'h0, 8'h40, 32'h0000_0000, rdat, rerr);
    `CHK(rerr, 1'h1)
    i_cai_field_model.pulse(0, 2);
    idle(8);
    rdchk(cai_pkg::OFS_STATUS, 32'h0000_0405);
    wr(cai_pkg::OFS_CTRL0, 32'h0000_0008);
    wr(cai_pkg::OFS_CTRL0, 32'h0000_0000);
    rdchk(cai_pkg::OFS_STATUS, 32'h0000_0404);
    v = $random(seed);
    wr(cai_pkg::OFS_MODE, 32'h0000_0001);
    wr(cai_pkg::OFS_COUNT0, v);
    i_cai_field_model.drive(0, 1'h1);
    idle(8);
    `CHK(counterEnable[0], 1'h1)
    rdchk(cai_pkg::OFS_STATUS, 32'h0000_041D);
    rdchk(cai_pkg::OFS_COUNT0, v);
    i_cai_field_model.drive(0, 1'h0);
    idle(8);
    `CHK(counterEnable[0], 1'h0)
    wr(cai_pkg::OFS_CTRL0, 32'h0000_0001);
    idle(2);
    `CHK(counterEnable[0], 1'h1)
    countTick <= 2'h1;
    idle(5);
    // Ticks while the clock enable is low must not count.
    clkEn <= 1'h0;
    idle(3);
    clkEn <= 1'h1;
    countTick <= 2'h0;
    rdchk(cai_pkg::OFS_COUNT0, v + 32'h0000_0005);
    wr(cai_pkg::OFS_CTRL0, 32'h0000_0008);
    wr(cai_pkg::OFS_CTRL0, 32'h0000_0000);
    // Pass 0 single code, pass 1 continuous code, pass 2 continuous with one-shot bit.
    for (int k = 0; k < 3; k++) begin
      ctl = (k == 2) ? 32'h0000_0040 : 32'h0000_0000;
      ld = $random(seed);
      v = $random(seed);
      v2 = $random(seed);
      wr(cai_pkg::OFS_CTRL0, ctl | 32'h0000_0002);
      wr(cai_pkg::OFS_MODE, (k == 0) ? 32'h0000_0002 : 32'h0000_0003);
      wr(cai_pkg::OFS_LOAD0, ld);
      wr(cai_pkg::OFS_COUNT0, v);
      wr(cai_pkg::OFS_CTRL0, ctl);
      i_cai_field_model.pulse(0, 2);
      idle(8);
      rdchk(cai_pkg::OFS_LATCH0, v);
      rdchk(cai_pkg::OFS_COUNT0, ld);
      wr(cai_pkg::OFS_COUNT0, v2);
      i_cai_field_model.pulse(0, 3);
      idle(8);
      rdchk(cai_pkg::OFS_LATCH0, exp_latch(k, v, v2));
    end
    // Re-arm first, so that only the off bits can be what blocks the edge.
    wr(cai_pkg::OFS_CTRL0, 32'h0000_0002);
    for (int k = 0; k < 2; k++) begin
      wr(cai_pkg::OFS_CTRL0, (k == 0) ? 32'h0000_0004 : 32'h0000_0002);
      v = $random(seed);
      wr(cai_pkg::OFS_COUNT0, v);
      i_cai_field_model.pulse(0, 2);
      idle(8);
      rdchk(cai_pkg::OFS_COUNT0, v);
    end
    wr(cai_pkg::OFS_CTRL0, 32'h0000_0000);
    v = $random(seed);
    wr(cai_pkg::OFS_COUNT0, v);
    wr(cai_pkg::OFS_CTRL0, 32'h0000_0020);
    rdchk(cai_pkg::OFS_LATCH0, v);
    rdchk(cai_pkg::OFS_COUNT0, ld);
    apb(1'h0, cai_pkg::OFS_STATUS, 32'h0000_0000, rdat, rerr);
    `CHK(rdat[cai_pkg::STS_SOFT_EVENT], 1'h1)
    wr(cai_pkg::OFS_CTRL0, 32'h0000_0000);
    i_cai_field_model.drive(1, 1'h1);
    foreach (codes[i]) begin
      code = codes[i][3:0];
      wr(cai_pkg::OFS_MODE, {24'h00_0000, code, 4'h0});
      idle(8);
      `CHK(pwmAuxRoute[1], exp_route(code))
      `CHK(pwmAuxLevel[1], exp_route(code))
      apb(1'h0, cai_pkg::OFS_STATUS, 32'h0000_0000, rdat, rerr);
      `CHK(rdat[8 + cai_pkg::STS_CODE_RSVD], exp_rsvd(code))
      if (code == 4'hF) begin
        `CHK(rdat[8 + cai_pkg::STS_AUX_LEVEL], 1'h1)
      end
    end
    wr(cai_pkg::OFS_MODE, 32'h0000_0004);
    idle(2);
    `CHK(counterEnable[0], 1'h0)
    wr(cai_pkg::OFS_CTRL0, 32'h0000_0010);
    idle(2);
    `CHK(counterEnable[0], 1'h1)
    i_cai_field_model.drive(1, 1'h0);
    idle(8);
    `CHK(counterEnable[0], 1'h0)
    wr(cai_pkg::OFS_CTRL1, 32'h0000_0010);
    wr(cai_pkg::OFS_MODE, 32'h0000_0050);
    ld = $random(seed);
    wr(cai_pkg::OFS_LOAD1, ld);
    for (int k = 0; k < 2; k++) begin
      v = $random(seed);
      wr(cai_pkg::OFS_COUNT1, v);
      i_cai_field_model.pulse(1, 2);
      idle(8);
      rdchk(cai_pkg::OFS_LATCH1, v);
    end
    rdchk(cai_pkg::OFS_COUNT1, ld);
    `CHK(counterEnable[1], 1'h0)
    i_cai_field_model.drive(0, 1'h1);
    idle(8);
    `CHK(counterEnable[1], 1'h1)
    end_of_test();
  end
endmodule // counter_aux_input_functions_bench
